// file: common/lbox_pkg.sv
// constants shared by the letterbox line detector and its helpers
//
// What this block does
// - sum line luma, compare at line end
// - threshold field resets to 01100, scales content
// - top run needs six black lines
// - top count reported at 0x9B
// - default search starts with active video
// - start-line field, default 0100 is line 23
// - top window closes at field midpoint
// - bottom needs six lines, reported at 0x9D
// - bottom window from midpoint to end line
// - subtitle-split bottom block gives mid count 0x9C
// - no subtitle: mid count equals bottom count
// - counts appear two fields after measurement
// - count registers read-only, writes ignored
// - end-line field defaults 1101, last active line
package lbox_pkg;

	// widths of the datapath
	localparam int DATA_W    = 8;
	localparam int LINE_W    = 10;
	localparam int SUM_W     = 20;
	localparam int THR_SHIFT = 10;

	// register offsets on the serial register port
	localparam logic [7:0] OFS_COUNT_TOP    = 8'h9B;
	localparam logic [7:0] OFS_COUNT_MID    = 8'h9C;
	localparam logic [7:0] OFS_COUNT_BOTTOM = 8'h9D;
	localparam logic [7:0] OFS_THRESHOLD    = 8'hDC;
	localparam logic [7:0] OFS_WINDOW       = 8'hDD;

	// field positions inside the window register
	localparam int START_POS = 4;
	localparam int END_POS   = 0;

	// reset values
	localparam logic [4:0]        THRESHOLD_RST   = 5'h0C;
	localparam logic [3:0]        START_LINE_RST  = 4'h4;
	localparam logic [3:0]        END_LINE_RST    = 4'hD;
	localparam logic [LINE_W-1:0] FIELD_LINES_RST = 10'h106;

	// line arithmetic: start code 4 is line 23, end code 13 is the last line
	localparam logic [LINE_W-1:0] START_LINE_BASE = 10'h013;
	localparam logic [LINE_W-1:0] END_LINE_LAST   = 10'h00D;

	// run qualification
	localparam logic [7:0] MIN_RUN     = 8'h06;
	localparam logic [7:0] MID_MIN_RUN = 8'h02;

	// luma code of black; only content above it adds to the line sum
	localparam logic [7:0] BLACK_LEVEL = 8'h10;

endpackage : lbox_pkg

// file: hw/line_luma_energy.sv
// per-line luminance accumulator and black-line classifier
`timescale 1ns/100ps
`default_nettype none
module line_luma_energy
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// video from the datapath
	input  wire logic [lbox_pkg::DATA_W-1:0] luma,
	input  wire logic                      active_pix,
	input  wire logic                      line_end,
	// control
	input  wire logic [4:0]                thr_code,
	// result
	output logic                           line_done,
	output logic                           line_black
);
	import lbox_pkg::*;

	logic [SUM_W-1:0] sum_ff;
	logic             done_ff;
	logic             black_ff;
	wire  [7:0]       mag;
	wire  [SUM_W-1:0] thr;
	wire              is_black;

	// only content above black counts, so sync tip and setup add nothing
	assign mag      = (luma > BLACK_LEVEL) ? 8'(luma - BLACK_LEVEL) : 8'h00;
	assign thr      = SUM_W'(thr_code) << THR_SHIFT;
	assign is_black = sum_ff < thr;

	// sum over active samples, judge and restart at line end
	always_ff @(posedge core_clk)
	begin
		if (srst || line_end)
			sum_ff <= '0;
		else if (active_pix)
			sum_ff <= sum_ff + SUM_W'(mag);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			done_ff  <= 1'b0;
			black_ff <= 1'b0;
		end
		else
		begin
			done_ff  <= line_end;
			black_ff <= line_end ? is_black : black_ff;
		end
	end

	assign line_done  = done_ff;
	assign line_black = black_ff;

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	line_class_a: assert property (line_end |=> line_done && line_black == $past(is_black))
		else $error("line class does not follow the line sum");

endmodule : line_luma_energy
`default_nettype wire

// file: hw/black_run_counter.sv
// counter of consecutive black lines inside a detection window
`timescale 1ns/100ps
`default_nettype none
module black_run_counter
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// control
	input  wire logic       clear,
	input  wire logic       step,
	input  wire logic       black,
	input  wire logic       hold_break,
	// result
	output logic [7:0]      run,
	output logic            qualified
);
	import lbox_pkg::*;

	logic [7:0] run_ff;
	logic       broken_ff;
	wire        grow;

	// a top run freezes at the first picture line; a bottom run restarts
	assign grow = step && black && !broken_ff && (run_ff != 8'hFF);

	always_ff @(posedge core_clk)
	begin
		if (srst || clear)
		begin
			run_ff    <= 8'h00;
			broken_ff <= 1'b0;
		end
		else if (step && !black)
		begin
			run_ff    <= hold_break ? run_ff : 8'h00;
			broken_ff <= hold_break;
		end
		else if (grow)
			run_ff <= run_ff + 8'h01;
	end

	assign run       = run_ff;
	assign qualified = run_ff >= MIN_RUN;

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	run_step_a: assert property (grow && !clear |=> run == $past(run) + 8'h01)
		else $error("black run did not advance on a black line");

	run_zero_a: assert property (clear |=> run == 8'h00 && !qualified)
		else $error("black run not restarted at field start");

endmodule : black_run_counter
`default_nettype wire

// file: hw/letterbox_line_detector.sv
// letterbox detector: line windows, run bookkeeping and register file
`timescale 1ns/100ps
`default_nettype none
module letterbox_line_detector
(
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        srst,
	// video and timing from the sync logic
	input  wire logic [lbox_pkg::DATA_W-1:0] luma,
	input  wire logic                        active_pix,
	input  wire logic                        line_end,
	input  wire logic                        field_start,
	// register port
	input  wire logic [7:0]                  reg_addr,
	input  wire logic                        reg_wr_en,
	input  wire logic                        reg_rd_en,
	input  wire logic [7:0]                  reg_wdata,
	output logic      [7:0]                  reg_rdata
);
	import lbox_pkg::*;

	// control fields
	logic [4:0]        thr_code_ff;
	logic [3:0]        start_code_ff;
	logic [3:0]        end_code_ff;

	// line bookkeeping
	logic [LINE_W-1:0] line_num_ff;
	logic [LINE_W-1:0] field_lines_ff;

	// subtitle block tracking inside the bottom window
	logic              blk_ok_ff;
	logic [7:0]        blk_len_ff;

	// first and second field stages of the reported counts
	logic [7:0]        top1_ff;
	logic [7:0]        mid1_ff;
	logic [7:0]        bot1_ff;
	logic [7:0]        lbox_count_top_ff;
	logic [7:0]        lbox_count_mid_ff;
	logic [7:0]        lbox_count_bottom_ff;

	// read data
	logic [7:0]        rdata_ff;

	// wires
	wire               line_done;
	wire               line_black;
	wire [7:0]         top_run;
	wire [7:0]         bot_run;
	wire               top_ok;
	wire               bot_ok;
	wire [LINE_W-1:0]  top_start;
	wire [LINE_W-1:0]  mid_line;
	wire [LINE_W-1:0]  bot_end;
	wire               in_top;
	wire               in_bot;
	wire               blk_confirm;
	wire [7:0]         top_meas;
	wire [7:0]         bot_meas;
	wire [7:0]         mid_meas;
	wire               wr_thr;
	wire               wr_win;
	wire [7:0]         rd_mux;

	// line classification
	line_luma_energy u_energy
	(
		.core_clk   (core_clk),
		.srst       (srst),
		.luma       (luma),
		.active_pix (active_pix),
		.line_end   (line_end),
		.thr_code   (thr_code_ff),
		.line_done  (line_done),
		.line_black (line_black)
	);

	// top run stops growing at the first picture line
	black_run_counter u_top_run
	(
		.core_clk   (core_clk),
		.srst       (srst),
		.clear      (field_start),
		.step       (in_top),
		.black      (line_black),
		.hold_break (1'b1),
		.run        (top_run),
		.qualified  (top_ok)
	);

	// bottom run restarts on every picture line, so it ends at the window end
	black_run_counter u_bot_run
	(
		.core_clk   (core_clk),
		.srst       (srst),
		.clear      (field_start),
		.step       (in_bot),
		.black      (line_black),
		.hold_break (1'b0),
		.run        (bot_run),
		.qualified  (bot_ok)
	);

	// window edges; line numbers count from 1 at field start
	assign top_start = START_LINE_BASE + LINE_W'(start_code_ff);
	assign mid_line  = field_lines_ff >> 1;
	assign bot_end   = field_lines_ff - (END_LINE_LAST - LINE_W'(end_code_ff));

	// a judged line falls into at most one window
	assign in_top = line_done && (line_num_ff >= top_start) && (line_num_ff < mid_line);
	assign in_bot = line_done && (line_num_ff >= mid_line) && (line_num_ff <= bot_end);

	// second black line of a run opens a block that may hold subtitles
	assign blk_confirm = in_bot && line_black && !blk_ok_ff
		&& (bot_run == MID_MIN_RUN - 8'h01);

	// measured values of the field that is ending
	assign top_meas = top_ok ? top_run : 8'h00;
	assign bot_meas = bot_ok ? bot_run : 8'h00;
	assign mid_meas = !bot_ok ? 8'h00 : (blk_ok_ff ? blk_len_ff : bot_run);

	// register decode; count registers take no writes
	assign wr_thr = reg_wr_en && (reg_addr == OFS_THRESHOLD);
	assign wr_win = reg_wr_en && (reg_addr == OFS_WINDOW);

	// read mux; unused bits and unmapped offsets read zero
	assign rd_mux = (reg_addr == OFS_COUNT_TOP)    ? lbox_count_top_ff :
	                (reg_addr == OFS_COUNT_MID)    ? lbox_count_mid_ff :
	                (reg_addr == OFS_COUNT_BOTTOM) ? lbox_count_bottom_ff :
	                (reg_addr == OFS_THRESHOLD)    ? {3'h0, thr_code_ff} :
	                (reg_addr == OFS_WINDOW)       ? {start_code_ff, end_code_ff} :
	                8'h00;

	// software control fields
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			thr_code_ff   <= THRESHOLD_RST;
			start_code_ff <= START_LINE_RST;
			end_code_ff   <= END_LINE_RST;
		end
		else
		begin
			if (wr_thr)
				thr_code_ff <= reg_wdata[4:0];
			if (wr_win)
			begin
				start_code_ff <= reg_wdata[START_POS +: 4];
				end_code_ff   <= reg_wdata[END_POS +: 4];
			end
		end
	end

	// line counter; field length is taken from the previous field
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			line_num_ff    <= LINE_W'(1);
			field_lines_ff <= FIELD_LINES_RST;
		end
		else if (field_start)
		begin
			line_num_ff    <= LINE_W'(1);
			field_lines_ff <= line_num_ff - LINE_W'(1);
		end
		else if (line_done && line_num_ff != '1)
			line_num_ff <= line_num_ff + LINE_W'(1);
	end

	// subtitle block length counts black and subtitle lines alike
	always_ff @(posedge core_clk)
	begin
		if (srst || field_start)
		begin
			blk_ok_ff  <= 1'b0;
			blk_len_ff <= 8'h00;
		end
		else if (blk_confirm)
		begin
			blk_ok_ff  <= 1'b1;
			blk_len_ff <= MID_MIN_RUN;
		end
		else if (in_bot && blk_ok_ff && blk_len_ff != 8'hFF)
			blk_len_ff <= blk_len_ff + 8'h01;
	end

	// two field boundaries separate a measurement from its report
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			top1_ff              <= 8'h00;
			mid1_ff              <= 8'h00;
			bot1_ff              <= 8'h00;
			lbox_count_top_ff    <= 8'h00;
			lbox_count_mid_ff    <= 8'h00;
			lbox_count_bottom_ff <= 8'h00;
		end
		else if (field_start)
		begin
			top1_ff              <= top_meas;
			mid1_ff              <= mid_meas;
			bot1_ff              <= bot_meas;
			lbox_count_top_ff    <= top1_ff;
			lbox_count_mid_ff    <= mid1_ff;
			lbox_count_bottom_ff <= bot1_ff;
		end
	end

	// read data holds until the next read
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rdata_ff <= 8'h00;
		else if (reg_rd_en)
			rdata_ff <= rd_mux;
	end

	assign reg_rdata = rdata_ff;

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence field_edge_s;
		field_start;
	endsequence

	sequence two_fields_s;
		field_edge_s ##1 (!field_start) [*1] ##[0:1000] field_start;
	endsequence

	thr_reset_a: assert property ($fell(srst) |-> thr_code_ff == THRESHOLD_RST
		&& start_code_ff == START_LINE_RST && end_code_ff == END_LINE_RST)
		else $error("control fields not at their reset values");

	count_ro_a: assert property (reg_wr_en && !field_start && reg_addr inside {8'h9B, 8'h9C, 8'h9D}
		|=> $stable(lbox_count_top_ff) && $stable(lbox_count_mid_ff)
		&& $stable(lbox_count_bottom_ff))
		else $error("count register changed on a register write");

	// a top result taken at one field start must stand after the next one;
	// fields longer than the range leave this check vacuous
	two_field_a: assert property ((top_meas == 8'h09) ##0 two_fields_s
		|=> lbox_count_top_ff == 8'h09)
		else $error("top count not reported two fields later");

	stage_a: assert property (field_edge_s |=> bot1_ff == $past(bot_meas)
		&& lbox_count_bottom_ff == $past(bot1_ff))
		else $error("count stages did not shift at field start");

	top_min_a: assert property (top1_ff != 8'h00 |-> top1_ff >= 8'h06)
		else $error("top count below six lines");

	bot_min_a: assert property (field_start && bot_run < 8'h06 |=> bot1_ff == 8'h00)
		else $error("short bottom run was reported");

	mid_same_a: assert property (field_start && !blk_ok_ff |=> mid1_ff == bot1_ff)
		else $error("mid count differs without a subtitle block");

	win_excl_a: assert property (!(in_top && in_bot))
		else $error("line judged in both windows");

	top_start_a: assert property (in_top |-> line_num_ff >= 10'h013 + 10'(start_code_ff))
		else $error("top window opened before the start line");

	read_cnt_a: assert property (reg_rd_en && reg_addr == 8'h9D
		|=> reg_rdata == $past(lbox_count_bottom_ff))
		else $error("bottom count read back wrong");

endmodule : letterbox_line_detector
`default_nettype wire

// file: verification/test_letterbox_line_detector.sv
// self-checking bench for the letterbox line detector
`timescale 1ns/100ps
`default_nettype none
module test_letterbox_line_detector;
	import lbox_pkg::*;

	logic       core_clk;
	logic       srst;
	logic [7:0] luma;
	logic       active_pix;
	logic       line_end;
	logic       field_start;
	logic [7:0] reg_addr;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	int         err_total;
	int         checks;

	letterbox_line_detector uut
	(
		.core_clk    (core_clk),
		.srst        (srst),
		.luma        (luma),
		.active_pix  (active_pix),
		.line_end    (line_end),
		.field_start (field_start),
		.reg_addr    (reg_addr),
		.reg_wr_en   (reg_wr_en),
		.reg_rd_en   (reg_rd_en),
		.reg_wdata   (reg_wdata),
		.reg_rdata   (reg_rdata)
	);

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	// inputs always move 1 ns after the rising edge
	task tick;
		@(posedge core_clk);
		#1;
	endtask : tick

	task summarize;
		$display("checks=%0d errors=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		tick;
		reg_wr_en = 1'b0;
		// idle edge so a following access never lowers and raises a strobe at once
		tick;
	endtask : wr

	// read data is registered, so it is settled one edge after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr  = a;
		reg_rd_en = 1'b1;
		tick;
		reg_rd_en = 1'b0;
		chk(reg_rdata, exp, "register read");
		tick;
	endtask : rd

	task counts(input logic [7:0] t, input logic [7:0] m, input logic [7:0] b);
		rd(OFS_COUNT_TOP, t);
		rd(OFS_COUNT_MID, m);
		rd(OFS_COUNT_BOTTOM, b);
	endtask : counts

	// one line: n active samples of value v, then the line-end pulse
	task line(input int n, input logic [7:0] v);
		active_pix = 1'b1;
		luma       = v;
		repeat (n) tick;
		active_pix = 1'b0;
		luma       = 8'h00;
		line_end   = 1'b1;
		tick;
		line_end   = 1'b0;
		tick;
	endtask : line

	// field start is followed by two idle cycles before the next line end
	task new_field;
		field_start = 1'b1;
		tick;
		field_start = 1'b0;
		tick;
		tick;
	endtask : new_field

	// black lines use luma below black level, which must floor at zero;
	// 51 full samples sit just under the default threshold, 52 just over
	task field_pat;
		for (int n = 1; n <= 262; n++)
		begin
			if (n == 31)
				line(51, 8'hFF);
			else if ((n > 31 && n < 240) || (n > 241 && n < 246))
				line(52, 8'hFF);
			else
				line(1, 8'h05);
		end
	endtask : field_pat

	task field_flat;
		repeat (262) line(1, 8'h05);
	endtask : field_flat

	task reset_regs;
		rd(OFS_THRESHOLD, 8'h0C);
		rd(OFS_WINDOW, 8'h4D);
		counts(8'h00, 8'h00, 8'h00);
		wr(OFS_COUNT_TOP, 8'hAA);
		wr(OFS_COUNT_MID, 8'h55);
		wr(8'h00, 8'hFF);
		counts(8'h00, 8'h00, 8'h00);
		rd(8'h00, 8'h00);
		wr(OFS_THRESHOLD, 8'hFF);
		rd(OFS_THRESHOLD, 8'h1F);
		wr(OFS_THRESHOLD, 8'h0C);
	endtask : reset_regs

	// field sequence: each result must appear exactly two fields later
	// the first field runs from reset: a field start with no lines before it
	// would leave a zero field length and close both windows
	task video_run;
		field_pat;
		new_field;
		counts(8'h00, 8'h00, 8'h00);
		wr(OFS_THRESHOLD, 8'h00);
		field_flat;
		new_field;
		counts(8'h09, 8'h17, 8'h11);
		wr(OFS_THRESHOLD, 8'h0C);
		wr(OFS_WINDOW, 8'h5C);
		field_pat;
		new_field;
		counts(8'h00, 8'h00, 8'h00);
		wr(OFS_WINDOW, 8'h4D);
		field_flat;
		new_field;
		counts(8'h08, 8'h16, 8'h10);
		field_flat;
		new_field;
		counts(8'h6C, 8'h84, 8'h84);
	endtask : video_run

	// watchdog: the whole run is far shorter than this
	initial
	begin
		#600000;
		err_total++;
		summarize;
	end

	initial
	begin
		core_clk    = 1'b0;
		srst        = 1'b1;
		luma        = 8'h00;
		active_pix  = 1'b0;
		line_end    = 1'b0;
		field_start = 1'b0;
		reg_addr    = 8'h00;
		reg_wr_en   = 1'b0;
		reg_rd_en   = 1'b0;
		reg_wdata   = 8'h00;
		err_total   = 0;
		checks      = 0;
		repeat (8) tick;
		srst = 1'b0;
		reset_regs;
		video_run;
		summarize;
	end

endmodule : test_letterbox_line_detector
`default_nettype wire
